// ==== stop_mode_clock_controller.sv ====
// Behaviour
// - the oscillator enable output is low to let it run and high, the or of both stop requests, to halt it.
// - an internal counter measures the stabilization time, its terminal sized from time times frequency.
// - core reset stays low while system reset is low and rises only after the stabilization count.
// - system reset low asynchronously clears the counter, closes the clock gate and asserts core reset.
// - an active stop request asynchronously clears the counter and closes the gate, forcing a full recount.
// - at count f0 the clock gate opens; the core clock is the oscillator clock and the gate.
// - at count f5 core reset is released high, after the gate has opened.
// - the counter steps on each oscillator falling edge while no stop is requested and holds at ff.
// - clock good is high exactly while the counter equals fe and the hold-good control bit is clear.
// - the counter width is a named constant, eight bits here.
// - with a pll in use, a standby output puts the pll in standby during stop mode.
// - with pll and oscillator both restarting, the count covers pll lock plus oscillator settling.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module stop_mode_clock_controller
  import clkctl_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscillator_clock_in,
  input wire logic software_stop_request,
  input wire logic hardware_stop_request,
  input wire logic stop_acknowledge_in,
  input wire logic system_reset_n,
  output logic oscillator_enable_n,
  output logic gated_core_clock_out,
  output logic clock_good_release,
  output logic core_reset_n,
  output logic pll_standby_control
);

  // pin synchronisers
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s1_ff;
  logic [PIN_W-1:0] pins_s2_ff;

  assign pins_raw[PIN_OSC] = oscillator_clock_in;
  assign pins_raw[PIN_SW_STOP] = software_stop_request;
  assign pins_raw[PIN_HW_STOP] = hardware_stop_request;
  assign pins_raw[PIN_STOP_ACK] = stop_acknowledge_in;
  assign pins_raw[PIN_SYS_RST_N] = system_reset_n;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pins_s1_ff[gi] <= 1'b0;
          pins_s2_ff[gi] <= 1'b0;
        end else if (clock_enable) begin
          pins_s1_ff[gi] <= pins_raw[gi];
          pins_s2_ff[gi] <= pins_s1_ff[gi];
        end
      end
    end
  endgenerate

  logic osc_s;
  logic stop_s;
  logic ack_s;
  logic sys_run_s;
  assign osc_s = pins_s2_ff[PIN_OSC];
  assign stop_s = pins_s2_ff[PIN_SW_STOP] | pins_s2_ff[PIN_HW_STOP];
  assign ack_s = pins_s2_ff[PIN_STOP_ACK];
  assign sys_run_s = pins_s2_ff[PIN_SYS_RST_N];

  // asynchronous clear terms
  logic sys_clear;
  logic stop_clear;
  logic stop_pin;
  assign sys_clear = rst | ~system_reset_n;
  // either raw stop pin clears at once, before the synchronisers see it
  assign stop_pin = software_stop_request | hardware_stop_request;
  assign stop_clear = sys_clear | stop_pin;

  // oscillator falling edge detection
  logic osc_prev_ff;
  logic nxt_osc_prev;
  logic osc_fall;

  always_comb begin
    nxt_osc_prev = osc_s;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_prev_ff <= 1'b0;
    end else if (clock_enable) begin
      osc_prev_ff <= nxt_osc_prev;
    end
  end

  assign osc_fall = osc_prev_ff & ~osc_s;

  // stabilization counter, gate and clock good
  logic [CNT_W-1:0] counter_ff;
  logic [CNT_W-1:0] nxt_counter;
  logic gate_ff;
  logic nxt_gate;
  logic good_ff;
  logic nxt_good;

  always_comb begin
    nxt_counter = counter_ff;
    nxt_gate = gate_ff;
    if (stop_s) begin
      nxt_counter = CNT_RESET;
      nxt_gate = 1'b0;
    end else if (osc_fall) begin
      if (counter_ff == CNT_GATE_ON) begin
        nxt_gate = 1'b1;
      end
      if (counter_ff != CNT_STOP) begin
        nxt_counter = counter_ff + CNT_ONE;
      end
    end
    nxt_good = (nxt_counter == CNT_GOOD);
  end

  always_ff @(posedge clock or posedge stop_clear) begin
    if (stop_clear) begin
      counter_ff <= CNT_RESET;
      gate_ff <= 1'b0;
      good_ff <= 1'b0;
    end else if (clock_enable) begin
      counter_ff <= nxt_counter;
      gate_ff <= nxt_gate;
      good_ff <= nxt_good;
    end
  end

  // core reset, cleared only by rst or system reset
  logic core_run_ff;
  logic nxt_core_run;

  always_comb begin
    nxt_core_run = core_run_ff;
    if (sys_run_s && !stop_s && osc_fall &&
        counter_ff == CNT_CORE_RUN) begin
      nxt_core_run = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_clear) begin
    if (sys_clear) begin
      core_run_ff <= 1'b0;
    end else if (clock_enable) begin
      core_run_ff <= nxt_core_run;
    end
  end

  // control register and derived pin outputs
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic osc_en_n_ff;
  logic nxt_osc_en_n;
  logic gclk_ff;
  logic nxt_gclk;
  logic pll_stby_ff;
  logic nxt_pll_stby;
  logic good_out_ff;
  logic nxt_good_out;

  always_comb begin
    nxt_osc_en_n = stop_s;
    nxt_gclk = osc_s & gate_ff;
    nxt_pll_stby = stop_s & ctrl_ff[CTRL_PLL_USED];
    // clock good follows the counter value in the same cycle
    nxt_good_out = nxt_good & ~ctrl_ff[CTRL_HOLD_GOOD];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_en_n_ff <= 1'b0;
      pll_stby_ff <= 1'b0;
    end else if (clock_enable) begin
      osc_en_n_ff <= nxt_osc_en_n;
      pll_stby_ff <= nxt_pll_stby;
    end
  end

  // gated clock and clock good drop with the asynchronous clears
  always_ff @(posedge clock or posedge stop_clear) begin
    if (stop_clear) begin
      gclk_ff <= 1'b0;
      good_out_ff <= 1'b0;
    end else if (clock_enable) begin
      gclk_ff <= nxt_gclk;
      good_out_ff <= nxt_good_out;
    end
  end

  assign oscillator_enable_n = osc_en_n_ff;
  assign gated_core_clock_out = gclk_ff;
  assign pll_standby_control = pll_stby_ff;
  assign clock_good_release = good_out_ff;
  assign core_reset_n = core_run_ff;

  // phase tracking and restart counting
  phase_t phase_ff;
  phase_t nxt_phase;
  logic [RESTART_W-1:0] restarts_ff;
  logic [RESTART_W-1:0] nxt_restarts;

  always_comb begin
    nxt_phase = phase_ff;
    nxt_restarts = restarts_ff;
    case (phase_ff)
      PH_STOPPED: begin
        if (!stop_s) begin
          nxt_phase = PH_COUNTING;
          // each exit from stop counts as a restart until the count reaches RESTART_MAX
          if (restarts_ff != RESTART_MAX) begin
            nxt_restarts = restarts_ff + RESTART_ONE;
          end
        end
      end
      PH_COUNTING: begin
        if (stop_s) begin
          nxt_phase = PH_STOPPED;
        end else if (gate_ff) begin
          nxt_phase = PH_GATED;
        end
      end
      PH_GATED: begin
        if (stop_s) begin
          nxt_phase = PH_STOPPED;
        end else if (core_run_ff) begin
          nxt_phase = PH_RUNNING;
        end
      end
      PH_RUNNING: begin
        if (stop_s) begin
          nxt_phase = PH_STOPPED;
        end
      end
      default: begin
        nxt_phase = PH_STOPPED;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_ff <= PH_STOPPED;
      restarts_ff <= '0;
    end else if (clock_enable) begin
      phase_ff <= nxt_phase;
      restarts_ff <= nxt_restarts;
    end
  end

  // apb slave, zero wait states
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rd_word;
  logic [ST_W-1:0] status_word;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;

  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable & pready_ff;

  always_comb begin
    status_word = '0;
    status_word[ST_GATE] = gate_ff;
    status_word[ST_CORE_RUN] = core_run_ff;
    status_word[ST_GOOD] = good_ff;
    status_word[ST_STOPPED] = stop_s;
    status_word[ST_STOP_ACK] = ack_s;
    status_word[ST_PLL_STBY] = pll_stby_ff;
    status_word[ST_SYS_RST] = ~sys_run_s;
  end

  always_comb begin
    rd_word = DATA_ZERO;
    mapped = 1'b1;
    case (apb_req.paddr)
      ADDR_CTRL: begin
        rd_word[CTRL_W-1:0] = ctrl_ff;
      end
      ADDR_STATUS: begin
        rd_word[ST_W-1:0] = status_word;
      end
      ADDR_RESTARTS: begin
        rd_word[RESTART_W-1:0] = restarts_ff;
      end
      ADDR_COUNTER: begin
        rd_word[CNT_W-1:0] = counter_ff;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_ctrl = ctrl_ff;
    // read data is captured in setup and shown in the access cycle
    if (setup) begin
      nxt_pready = 1'b1;
      nxt_pslverr = ~mapped;
      nxt_prdata = apb_req.pwrite ? DATA_ZERO : rd_word;
    end
    // a write lands only at the access edge
    if (access && apb_req.pwrite && apb_req.paddr == ADDR_CTRL) begin
      nxt_ctrl = apb_req.pwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_ff <= DATA_ZERO;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      ctrl_ff <= CTRL_RESET;
    end else if (clock_enable) begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule : stop_mode_clock_controller

// ==== clkctl_pkg.sv ====
package clkctl_pkg;

  // stabilization counter layout
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_GATE_ON = 8'hF0;
  localparam logic [CNT_W-1:0] CNT_CORE_RUN = 8'hF5;
  localparam logic [CNT_W-1:0] CNT_GOOD = 8'hFE;
  localparam logic [CNT_W-1:0] CNT_STOP = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // clock figures
  localparam int CLOCK_HZ = 50_000_000;
  localparam int CLOCK_NS = 20;

  // pin synchroniser
  localparam int SYNC_STAGES = 2;
  localparam int PIN_W = 5;
  localparam int PIN_OSC = 0;
  localparam int PIN_SW_STOP = 1;
  localparam int PIN_HW_STOP = 2;
  localparam int PIN_STOP_ACK = 3;
  localparam int PIN_SYS_RST_N = 4;

  // apb register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_RESTARTS = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_COUNTER = 12'h00C;

  // control fields
  localparam int CTRL_PLL_USED = 0;
  localparam int CTRL_HOLD_GOOD = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int CTRL_W = 2;

  // status fields
  localparam int ST_GATE = 0;
  localparam int ST_CORE_RUN = 1;
  localparam int ST_GOOD = 2;
  localparam int ST_STOPPED = 3;
  localparam int ST_STOP_ACK = 4;
  localparam int ST_PLL_STBY = 5;
  localparam int ST_SYS_RST = 6;
  localparam int ST_W = 7;

  localparam int RESTART_W = 16;
  localparam logic [RESTART_W-1:0] RESTART_ONE = 16'h0001;
  localparam logic [RESTART_W-1:0] RESTART_MAX = 16'hFFFF;

  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef enum logic [1:0] {
    PH_STOPPED,
    PH_COUNTING,
    PH_GATED,
    PH_RUNNING
  } phase_t;

endpackage : clkctl_pkg

// ==== clkctl_chk_assertions.sv ====
`timescale 1ns/1ps
module clkctl_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic software_stop_request,
  input wire logic hardware_stop_request,
  input wire logic system_reset_n,
  input wire logic oscillator_clock_in,
  input wire logic oscillator_enable_n,
  input wire logic gated_core_clock_out,
  input wire logic clock_good_release,
  input wire logic core_reset_n,
  input wire logic pll_standby_control
);
  logic stp;
  assign stp = software_stop_request | hardware_stop_request;
  logic [2:0] en_seen_ff;
  always_ff @(posedge clock) begin
    en_seen_ff <= {en_seen_ff[1:0], clock_enable};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !clock_enable);
  AST_OSC_HALT: assert property (stp [*5] |-> oscillator_enable_n)
    else $error("osc runs in stop");
  AST_OSC_RUN: assert property (!stp [*5] |-> !oscillator_enable_n)
    else $error("osc halted");
  AST_SYS_RST: assert property (!system_reset_n [*4] |->
    !core_reset_n && !clock_good_release)
    else $error("core out of reset");
  AST_GATE_OFF: assert property (stp [*5] |-> !gated_core_clock_out)
    else $error("gated clock in stop");
  AST_GOOD_RUN: assert property (clock_good_release |-> core_reset_n)
    else $error("good before run");
  AST_GCLK_SRC: assert property ((gated_core_clock_out && (&en_seen_ff)) |->
    $past(oscillator_clock_in, 3) || $past(oscillator_clock_in, 2))
    else $error("gated clock not osc");
  AST_GOOD_SHORT: assert property ($rose(clock_good_release) |->
    ##[1:12] !clock_good_release)
    else $error("good too long");
  AST_PLL_OFF: assert property (!stp [*5] |-> !pll_standby_control)
    else $error("pll standby w/o stop");
endmodule : clkctl_chk

// ==== osc_model.sv ====
`timescale 1ns/1ps
module osc_model (
  input wire logic clock,
  input wire logic oscillator_enable_n,
  output logic oscillator_clock_in,
  output logic stop_acknowledge_in
);
  logic [1:0] div = 2'h0;
  assign stop_acknowledge_in = 1'b1;
  initial oscillator_clock_in = 1'b0;
  always @(posedge clock) begin
    if (oscillator_enable_n) begin
      div <= 2'h0;
      oscillator_clock_in <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) oscillator_clock_in <= ~oscillator_clock_in;
    end
  end
endmodule : osc_model

// ==== stop_mode_clock_controller_tb.sv ====
`timescale 1ns/1ps
module stop_mode_clock_controller_tb import clkctl_pkg::*; ;
  logic clock, rst, clock_enable, software_stop_request;
  logic hardware_stop_request, system_reset_n, oscillator_clock_in;
  logic stop_acknowledge_in, oscillator_enable_n, gated_core_clock_out;
  logic clock_good_release, core_reset_n, pll_standby_control;
  logic pready, pslverr, err;
  logic [31:0] prdata, rd, d;
  apb_req_t req;
  int fail_count, n_checks, seed, t, i;

  stop_mode_clock_controller i_dut (.clock(clock), .rst(rst),
    .clock_enable(clock_enable), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .oscillator_clock_in(oscillator_clock_in),
    .software_stop_request(software_stop_request),
    .hardware_stop_request(hardware_stop_request),
    .stop_acknowledge_in(stop_acknowledge_in),
    .system_reset_n(system_reset_n),
    .oscillator_enable_n(oscillator_enable_n),
    .gated_core_clock_out(gated_core_clock_out),
    .clock_good_release(clock_good_release),
    .core_reset_n(core_reset_n),
    .pll_standby_control(pll_standby_control));

  osc_model i_osc (.clock(clock),
    .oscillator_enable_n(oscillator_enable_n),
    .oscillator_clock_in(oscillator_clock_in),
    .stop_acknowledge_in(stop_acknowledge_in));

  task end_sim;
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    t = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    req <= '0;
    chk("pready", pready, 1'h1);
  endtask : apb

  initial begin
    clock = 1'b0;
    forever #(CLOCK_NS / 2) clock = ~clock;
  end

  initial begin
    #(CLOCK_NS * 20000);
    fail_count++;
    end_sim;
  end

  initial begin
    seed = 67;
    rst = 1'b1;
    clock_enable = 1'b1;
    req = '0;
    software_stop_request = 1'b0;
    hardware_stop_request = 1'b0;
    system_reset_n = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    chk("osc_en_n", oscillator_enable_n, 1'h0);
    chk("core_rst", core_reset_n, 1'h0);
    apb(1'b0, ADDR_COUNTER, DATA_ZERO);
    chk("cnt_sysrst", rd, DATA_ZERO);
    system_reset_n <= 1'b1;
    t = 0;
    while (core_reset_n !== 1'b1 && t < 4000) begin
      @(posedge clock);
      t++;
    end
    chk("run_late", t > 1900, 1'h1);
    apb(1'b0, ADDR_STATUS, DATA_ZERO);
    chk("gate_run", rd[1:0], 2'h3);
    d = DATA_ZERO;
    repeat (16) begin
      @(posedge clock);
      d = d + 32'(gated_core_clock_out);
    end
    chk("gclk_duty", d, 32'h0000_0008);
    repeat (120) @(posedge clock);
    apb(1'b0, ADDR_COUNTER, DATA_ZERO);
    chk("cnt_hold", rd, {24'h00_0000, CNT_STOP});
    apb(1'b0, ADDR_STATUS, DATA_ZERO);
    chk("status", rd, 32'h0000_0013);
    d = $random(seed);
    apb(1'b1, ADDR_CTRL, d);
    apb(1'b0, ADDR_CTRL, DATA_ZERO);
    chk("ctrl", rd, {30'h0000_0000, d[1:0]});
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    apb(1'b0, 12'h010, DATA_ZERO);
    chk("unmap_err", err, 1'h1);
    chk("unmap_dat", rd, DATA_ZERO);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_CTRL, (i == 0) ? 32'h0000_0001 : DATA_ZERO);
      software_stop_request <= (i == 0);
      hardware_stop_request <= (i == 1);
      repeat (6 + ($random(seed) & 7)) @(posedge clock);
      chk("osc_halt", oscillator_enable_n, 1'h1);
      chk("pll_stby", pll_standby_control, i == 0);
      apb(1'b0, ADDR_COUNTER, DATA_ZERO);
      chk("cnt_clr", rd, DATA_ZERO);
      chk("gclk_off", gated_core_clock_out, 1'h0);
      software_stop_request <= 1'b0;
      hardware_stop_request <= 1'b0;
      t = 0;
      while (clock_good_release !== 1'b1 && t < 4000) begin
        @(posedge clock);
        t++;
      end
      chk("recount", t > 1900, 1'h1);
      apb(1'b0, ADDR_COUNTER, DATA_ZERO);
      chk("cnt_good", rd, {24'h00_0000, CNT_GOOD});
    end
    clock_enable <= 1'b0;
    repeat (40) @(posedge clock);
    chk("freeze_good", clock_good_release, 1'h1);
    chk("freeze_run", core_reset_n, 1'h1);
    clock_enable <= 1'b1;
    apb(1'b0, ADDR_RESTARTS, DATA_ZERO);
    chk("restarts", rd, 32'h0000_0003);
    end_sim;
  end
endmodule : stop_mode_clock_controller_tb

bind stop_mode_clock_controller clkctl_chk i_chk (.clock(clock),
  .rst(rst), .clock_enable(clock_enable),
  .software_stop_request(software_stop_request),
  .hardware_stop_request(hardware_stop_request),
  .system_reset_n(system_reset_n),
  .oscillator_clock_in(oscillator_clock_in),
  .oscillator_enable_n(oscillator_enable_n),
  .gated_core_clock_out(gated_core_clock_out),
  .clock_good_release(clock_good_release),
  .core_reset_n(core_reset_n),
  .pll_standby_control(pll_standby_control));
